//--- verilog/spi_config_error_status.sv
// Configuration error status word of a dual/quad capable SPI core, with control and interrupt registers.
// Assumes an APB master on pclk, and a transmit queue that reports each entry it accepts on tx_push.
//
// Overview of operation
// - The status word at 0x64 is read-only, writes leave it unchanged, and bits 31:11 read as zero.
// - In dual or quad mode bit 10 sets when the first queue entry after reset is not a supported command.
// - Bit 9 sets when loopback is on outside standard mode and stays 0 while loopback is off.
// - Loopback outside standard mode also raises its interrupt status bit.
// - In dual or quad mode bit 8 sets while least-significant-first order is selected.
// - Bit 7 resets to 1 and in dual or quad mode shows 1 while slave and 0 once master is selected.
// - In dual or quad mode bit 6 sets when clock polarity and phase are 01 or 10.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`include "spi_cfg_defines.svh"

module spi_config_error_status #(
    parameter int                     ADDR_W   = 8,
    parameter spi_cfg_pkg::spi_mode_t SPI_MODE = spi_cfg_pkg::MODE_QUAD,
    parameter int                     N_CMD    = 8,
    parameter logic [N_CMD*8-1:0]     CMD_LIST = {8'h03, 8'h0B, 8'h3B, 8'h6B, 8'h02, 8'h05, 8'h9F, 8'h06}
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clk_en,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    input  wire spi_cfg_pkg::tx_push_t tx_push,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq
);
    import spi_cfg_pkg::*;

    // Mode is fixed at build time; a standard-mode build keeps every flag but bit 7 clear
    localparam logic NON_STD = (SPI_MODE != MODE_STD);

    ctrl_t       ctrl_q;
    ctrl_t       ctrl_d;
    flags_t      flags_q;
    flags_t      flags_d;
    flags_t      events;
    flags_t      stat_q;
    flags_t      stat_d;
    flags_t      mask_q;
    flags_t      mask_d;
    logic        first_q;
    logic        first_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic        irq_q;
    logic        irq_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        wr_done;
    logic        rd_take;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        addr_is = (a == ADDR_W'(off));
    endfunction

    function automatic logic cmd_ok(input logic [7:0] c);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < N_CMD; i++)
        begin
            if (CMD_LIST[i*8 +: 8] == c)
            begin
                hit = 1'b1;
            end
        end
        cmd_ok = hit;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = addr_is(a, `CCW_OFFSET) || addr_is(a, `CSW_OFFSET) ||
                 addr_is(a, `IRQ_STAT_OFFSET) || addr_is(a, `IRQ_MASK_OFFSET);
    endfunction

    // Every access gets one wait state plus any cycles with clk_en low: pready rises in the second enabled access cycle
    assign rd_take = psel && penable && !pready_q;
    assign wr_done = psel && penable && pready_q && pwrite;

    always_comb
    begin
        ctrl_d    = ctrl_q;
        mask_d    = mask_q;
        first_d   = first_q;
        flags_d   = flags_q;
        stat_d    = stat_q;
        pready_d  = rd_take;
        pslverr_d = 1'b0;
        prdata_d  = 32'h0000_0000;
        irq_d     = irq_q;

        // The status word has no write path at all
        if (wr_done && addr_is(paddr, `CCW_OFFSET))
        begin
            ctrl_d.loop      = pwdata[`CCW_LOOP_BIT];
            ctrl_d.master    = pwdata[`CCW_MASTER_BIT];
            ctrl_d.cpol      = pwdata[`CCW_CPOL_BIT];
            ctrl_d.cpha      = pwdata[`CCW_CPHA_BIT];
            ctrl_d.lsb_first = pwdata[`CCW_LSB_BIT];
        end
        if (wr_done && addr_is(paddr, `IRQ_MASK_OFFSET))
        begin
            mask_d = flags_t'(pwdata[`CSW_CMD_BIT:`CSW_FLAG_LSB]);
        end

        // Only the very first entry is judged; later commands go unchecked
        if (tx_push.valid && !first_q)
        begin
            first_d = 1'b1;
            if (NON_STD && !cmd_ok(tx_push.data))
            begin
                flags_d.cmd = 1'b1;
            end
        end

        // Level flags follow the control word one cycle late
        flags_d.loop    = NON_STD && ctrl_q.loop;
        flags_d.msb     = NON_STD && ctrl_q.lsb_first;
        flags_d.slave   = NON_STD ? !ctrl_q.master : 1'b1;
        flags_d.clk_fmt = NON_STD && (ctrl_q.cpol ^ ctrl_q.cpha);

        // A rising flag is an event; a flag held high raises only one
        events = flags_d & ~flags_q;

        // Write one to clear, and a new event in the same cycle wins
        if (wr_done && addr_is(paddr, `IRQ_STAT_OFFSET))
        begin
            stat_d = stat_d & ~flags_t'(pwdata[`CSW_CMD_BIT:`CSW_FLAG_LSB]);
        end
        stat_d = stat_d | events;

        irq_d = |(stat_d & mask_d);

        if (rd_take)
        begin
            pslverr_d = !mapped(paddr);
            if (!pwrite)
            begin
                if (addr_is(paddr, `CSW_OFFSET))
                begin
                    prdata_d[`CSW_CMD_BIT:`CSW_FLAG_LSB] = flags_q;
                end
                else if (addr_is(paddr, `CCW_OFFSET))
                begin
                    prdata_d[`CCW_LOOP_BIT]   = ctrl_q.loop;
                    prdata_d[`CCW_MASTER_BIT] = ctrl_q.master;
                    prdata_d[`CCW_CPOL_BIT]   = ctrl_q.cpol;
                    prdata_d[`CCW_CPHA_BIT]   = ctrl_q.cpha;
                    prdata_d[`CCW_LSB_BIT]    = ctrl_q.lsb_first;
                end
                else if (addr_is(paddr, `IRQ_STAT_OFFSET))
                begin
                    prdata_d[`CSW_CMD_BIT:`CSW_FLAG_LSB] = stat_q;
                end
                else if (addr_is(paddr, `IRQ_MASK_OFFSET))
                begin
                    prdata_d[`CSW_CMD_BIT:`CSW_FLAG_LSB] = mask_q;
                end
                else
                begin
                    prdata_d = 32'h0000_0000;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q    <= `CCW_RESET;
            mask_q    <= `IRQ_MASK_RESET;
            flags_q   <= `FLAGS_RESET;
            stat_q    <= 5'h00;
            first_q   <= 1'b0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            irq_q     <= 1'b0;
        end
        else if (clk_en)
        begin
            ctrl_q    <= ctrl_d;
            mask_q    <= mask_d;
            flags_q   <= flags_d;
            stat_q    <= stat_d;
            first_q   <= first_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
            irq_q     <= irq_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_CSW_RO_READ: assert property (
        (clk_en && rd_take && !pwrite && addr_is(paddr, `CSW_OFFSET))
        |=> (prdata_q[`CSW_RSVD_MSB:`CSW_RSVD_LSB] == 21'h000000) && !pslverr_q
            && (prdata_q[`CSW_CMD_BIT:`CSW_FLAG_LSB] == $past(flags_q)))
        else $error("Status word read returned wrong data");

    AST_CMD_FIRST: assert property (
        (clk_en && tx_push.valid && !first_q && (NON_STD && !cmd_ok(tx_push.data)))
        |=> flags_q.cmd && first_q)
        else $error("Unsupported first command did not raise the command flag");

    AST_CMD_HOLD: assert property (
        (clk_en && first_q && !flags_q.cmd) |=> !flags_q.cmd)
        else $error("Command flag set after the first queue entry");

    AST_LOOP_OFF: assert property (
        (clk_en && !ctrl_q.loop) |=> !flags_q.loop)
        else $error("Loopback flag set while loopback is off");

    AST_LOOP_IRQ: assert property (
        (clk_en && NON_STD && ctrl_q.loop && !flags_q.loop) |=> flags_q.loop && stat_q.loop)
        else $error("Loopback misuse did not raise its interrupt status");

    AST_MSB_FLAG: assert property (
        clk_en |=> (flags_q.msb == (NON_STD && $past(ctrl_q.lsb_first))))
        else $error("Bit order flag does not follow the control word");

    AST_SLAVE_FLAG: assert property (
        (clk_en && NON_STD) |=> (flags_q.slave == !$past(ctrl_q.master)))
        else $error("Slave flag does not follow the master bit");

    AST_CLK_FMT: assert property (
        (clk_en && NON_STD && ctrl_q.cpol != ctrl_q.cpha)
        |=> flags_q.clk_fmt)
        else $error("Clock format 01 or 10 not flagged");

    AST_CLK_FMT_IRQ: assert property (
        (clk_en && NON_STD && (ctrl_q.cpol != ctrl_q.cpha) && !flags_q.clk_fmt)
        |=> stat_q.clk_fmt)
        else $error("Clock format error did not raise its interrupt status");

    AST_CLK_FMT_OK: assert property (
        (clk_en && (ctrl_q.cpol == ctrl_q.cpha))
        |=> !flags_q.clk_fmt)
        else $error("Clock format 00 or 11 flagged");

    AST_IRQ_LEVEL: assert property (
        clk_en |=> (irq_q == |(stat_q & mask_q)))
        else $error("Interrupt output disagrees with masked status");

    AST_STAT_STICKY: assert property (
        (clk_en && !(wr_done && addr_is(paddr, `IRQ_STAT_OFFSET)))
        |=> ((stat_q & $past(stat_q)) == $past(stat_q)))
        else $error("Interrupt status bit cleared without a write");

    AST_PREADY_PULSE: assert property (
        (clk_en && pready_q)
        |=> !pready_q)
        else $error("Bus answer stood longer than one cycle");

    AST_CSW_NO_WRITE: assert property (
        (clk_en && wr_done && addr_is(paddr, `CSW_OFFSET))
        |=> $stable(ctrl_q) && $stable(mask_q))
        else $error("Write to the status word changed a register");

    AST_UNMAPPED: assert property (
        (clk_en && rd_take && !mapped(paddr))
        |=> pslverr_q && (prdata_q == 32'h0000_0000))
        else $error("Unmapped address not answered with an error");

    AST_IDLE_BUS: assert property (
        (clk_en && !rd_take)
        |=> !pready_q && !pslverr_q && (prdata_q == 32'h0000_0000))
        else $error("Bus outputs not quiet outside an answer");

    AST_CMD_GOOD: assert property (
        (clk_en && tx_push.valid && !first_q && cmd_ok(tx_push.data))
        |=> !flags_q.cmd && first_q)
        else $error("Supported first command raised the command flag");

    AST_CMD_STICKY: assert property (
        (clk_en && flags_q.cmd)
        |=> flags_q.cmd)
        else $error("Command flag cleared before reset");

    AST_FIRST_STICKY: assert property (
        (clk_en && first_q)
        |=> first_q)
        else $error("First entry marker cleared before reset");

    AST_LOOP_SET: assert property (
        (clk_en && NON_STD && ctrl_q.loop)
        |=> flags_q.loop)
        else $error("Loopback outside standard mode not flagged");

endmodule

//--- include/spi_cfg_defines.svh
// Offsets, field positions and reset values of the configuration error status block.
// Assumes byte addresses on a 32-bit APB, one aligned word per register.
`ifndef SPI_CFG_DEFINES_SVH
`define SPI_CFG_DEFINES_SVH

`define CCW_OFFSET       8'h60
`define CSW_OFFSET       8'h64
`define IRQ_STAT_OFFSET  8'h68
`define IRQ_MASK_OFFSET  8'h6C

`define CCW_LOOP_BIT     0
`define CCW_MASTER_BIT   2
`define CCW_CPOL_BIT     3
`define CCW_CPHA_BIT     4
`define CCW_LSB_BIT      5

`define CSW_CMD_BIT      10
`define CSW_FLAG_LSB     6
`define CSW_RSVD_MSB     31
`define CSW_RSVD_LSB     11

`define CCW_RESET        5'h00
`define FLAGS_RESET      5'h02
`define IRQ_MASK_RESET   5'h00

`endif

//--- include/spi_cfg_pkg.sv
// Types shared by the configuration error status block and its users.
// Offsets and bit positions live in spi_cfg_defines.svh.
package spi_cfg_pkg;

    typedef enum logic [1:0] {
        MODE_STD,
        MODE_DUAL,
        MODE_QUAD
    } spi_mode_t;

    // Order matches status bits 10 down to 6
    typedef struct packed {
        logic cmd;
        logic loop;
        logic msb;
        logic slave;
        logic clk_fmt;
    } flags_t;

    typedef struct packed {
        logic lsb_first;
        logic cpha;
        logic cpol;
        logic master;
        logic loop;
    } ctrl_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } tx_push_t;

endpackage

//--- sim/tb.sv
// Self-checking bench for the configuration error status block, an APB master and scenario tasks.
// Assumes the default quad mode and the default supported command list of the design.
`timescale 1ns/10ps
`include "spi_cfg_defines.svh"

module tb;
    import spi_cfg_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        clk_en;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    tx_push_t    tx_push;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          num_errors;
    int          cmp_count;
    int          cycles;
    // Control values and the status word each must produce
    logic [31:0] ctl_tab [7] = '{32'h04, 32'h05, 32'h24, 32'h0C, 32'h14, 32'h1C, 32'h00};
    logic [31:0] exp_tab [7] = '{32'h400, 32'h600, 32'h500, 32'h440, 32'h440, 32'h400, 32'h480};

    spi_config_error_status DUT (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .tx_push (tx_push),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .irq     (irq)
    );

    task automatic test_done;
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen high; the bench timeout ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset;
        apb(1'b0, `CSW_OFFSET, 32'h0);
        chk(rd, 32'h80);
        chk({31'h0, err}, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_read_only;
        apb(1'b1, `CSW_OFFSET, 32'hFFFFFFFF);
        apb(1'b0, `CSW_OFFSET, 32'h0);
        chk(rd, 32'h80);
        apb(1'b0, 8'h70, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask

    // Only the first entry after reset counts, so a later good command must not clear it
    task automatic t_command;
        @(posedge pclk);
        tx_push <= '{1'b1, 8'h77};
        @(posedge pclk);
        tx_push <= '{1'b1, 8'h03};
        @(posedge pclk);
        tx_push <= '{1'b0, 8'h00};
        apb(1'b0, `CSW_OFFSET, 32'h0);
        chk(rd, 32'h480);
    endtask

    task automatic t_control;
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, `CCW_OFFSET, ctl_tab[i]);
            apb(1'b0, `CSW_OFFSET, 32'h0);
            chk(rd, exp_tab[i]);
        end
    endtask

    task automatic t_irq;
        apb(1'b1, `IRQ_STAT_OFFSET, 32'hFFFFFFFF);
        apb(1'b1, `IRQ_MASK_OFFSET, 32'h200);
        apb(1'b0, `IRQ_MASK_OFFSET, 32'h0);
        chk(rd, 32'h200);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `CCW_OFFSET, 32'h05);
        apb(1'b0, `IRQ_STAT_OFFSET, 32'h0);
        chk(rd & 32'h200, 32'h200);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `CCW_OFFSET, 32'h04);
        apb(1'b1, `IRQ_STAT_OFFSET, 32'h200);
        apb(1'b0, `IRQ_STAT_OFFSET, 32'h0);
        chk(rd & 32'h200, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask

    // Three frozen cycles stretch a read from four periods to seven
    task automatic t_freeze;
        time t0;
        t0 = $time;
        fork
            apb(1'b0, `CSW_OFFSET, 32'h0);
            begin
                repeat (2) @(posedge pclk);
                clk_en <= 1'b0;
                repeat (3) @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        chk(rd, 32'h400);
        chk(32'($time - t0), 32'h46);
    endtask

    // A second reset re-arms the first entry check and restores every register
    task automatic t_rearm;
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        tx_push <= '{1'b1, 8'h03};
        @(posedge pclk);
        tx_push <= '{1'b1, 8'h77};
        @(posedge pclk);
        tx_push <= '{1'b0, 8'h00};
        apb(1'b0, `CSW_OFFSET, 32'h0);
        chk(rd, 32'h80);
        chk({31'h0, irq}, 32'h0);
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            test_done();
        end
    end

    initial
    begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tx_push = '{1'b0, 8'h00};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_read_only();
        t_command();
        t_control();
        t_irq();
        t_freeze();
        t_rearm();
        test_done();
    end
endmodule
